/* hdl/ars_store_path.sv */
/*
  Store path of a 40-bit two-accumulator datapath: accumulator stores,
  multiply-accumulate write-back, round, store saturation, barrel shifter.
  Assumes control inputs come from core logic on the same clock, and the
  accumulators are held by the caller; this block only reads them.
*/
// The placing of the registers and the address-and-strobe port are this design's own decisions.
//
// Operation
// - Multiply-accumulate class, bar four multiply forms, may store other accumulator rounded.
// - Post-increment write-back goes over the X write bus to any data address.
// - Register-direct write-back puts the rounded word into the pointer register.
// - Post-increment write-back stores at the pointer, then pointer grows by 2.
// - Rounding is combinational, yields 16 bits, mode bit picks style.
// - Without rounding, store the high word and drop the low word.
// - Conventional rounding adds bit 15 to the high word.
// - Convergent: exact half increments only when bit 16 is one.
// - Store-accumulator truncated or rounded, over X bus, through saturation.
// - Write-back data is always rounded.
// - Saturating a stored value never changes the source accumulator.
// - Saturation uses rounded value, source sign and round adder overflow.
// - Enabled saturation turns values above 0x007FFF into 0x7FFF.
// - Enabled saturation turns values below 0xFF8000 into 0x8000.
// - Saturation sign comes from source bit 39.
// - Disabled saturation passes the value unchanged.
// - Shifter does right arithmetic/logical or left shifts up to 16 in one cycle.
// - Signed amount: positive right, negative left, zero unchanged.
// - Shifter is 40 bits, word result is 16 bits.
// - X word enters at bits 16-31 for right, 0-15 for left shifts.
// - Configuration bit selects conventional or convergent rounding.
// - Configuration bit switches store saturation on or off.
`timescale 1ns/1ps
`include "ars_consts.svh"

module ars_store_path (
  // Clock, reset, enable
  input  wire logic                  CLK,
  input  wire logic                  NRST,
  input  wire logic                  CE,
  // Register port
  input  wire logic [3:0]            REG_ADDR,
  input  wire logic [15:0]           REG_WDATA,
  input  wire logic                  REG_WR,
  input  wire logic                  REG_RD,
  output logic      [15:0]           REG_RDATA,
  // Accumulators, read only
  input  wire logic [39:0]           ACC_A,
  input  wire logic [39:0]           ACC_B,
  // Store request
  input  wire logic                  OP_STB,
  input  wire ars_pkg::ars_op_type   OP_CODE,
  input  wire logic                  OP_DEST,
  input  wire ars_pkg::ars_wb_type   OP_WB_MODE,
  input  wire logic [15:0]           OP_ADDR,
  // X data write bus
  output logic                       XW_STB,
  output logic      [15:0]           XW_ADDR,
  output logic      [15:0]           XW_DATA,
  // Write-back pointer view
  output logic      [15:0]           WB_PTR,
  // Shift request
  input  wire logic                  SH_STB,
  input  wire ars_pkg::ars_shsrc_type SH_SRC,
  input  wire logic [5:0]            SH_AMOUNT,
  input  wire logic                  SH_ARITH,
  input  wire logic [15:0]           SH_XDATA,
  // Shift result
  output logic                       SH_DONE,
  output logic      [39:0]           SH_RESULT,
  output logic      [15:0]           SH_WORD
);

  ars_pkg::ars_state_type state_r;
  ars_pkg::ars_state_type state_nxt;

  ars_round_if rif ();

  ars_round_sat u_round_sat (
    .rif (rif.unit)
  );

  // Request decode
  logic        is_store;
  logic        is_rounded_store;
  logic        is_writeback;
  logic        wb_allowed;
  logic        use_other;
  logic [39:0] src_acc;

  always_comb begin
    is_store = OP_STB && ((OP_CODE == ars_pkg::OP_STORE_ACC_TRUNCATED) ||
                          (OP_CODE == ars_pkg::OP_STORE_ACC_ROUNDED));
    is_rounded_store = OP_STB && (OP_CODE == ars_pkg::OP_STORE_ACC_ROUNDED);
    // Only the multiply-accumulate class may write back; the four multiply forms and all other codes are barred
    case (OP_CODE)
      ars_pkg::OP_MULTIPLY_ACCUMULATE_CLASS: wb_allowed = 1'b1;
      ars_pkg::OP_PLAIN_MULTIPLY: wb_allowed = 1'b0;
      ars_pkg::OP_NEGATED_MULTIPLY: wb_allowed = 1'b0;
      ars_pkg::OP_DISTANCE_SQUARED: wb_allowed = 1'b0;
      ars_pkg::OP_DISTANCE_SQUARED_ACCUMULATE: wb_allowed = 1'b0;
      default: wb_allowed = 1'b0;
    endcase
    is_writeback = OP_STB && wb_allowed && (OP_WB_MODE != ars_pkg::WB_NONE);
    // Stores use the destination, write-back the other accumulator
    use_other = is_writeback ? !OP_DEST : OP_DEST;
    // Accumulators are only read here, never written back
    src_acc = use_other ? ACC_B : ACC_A;
  end

  // Round and saturation unit feed
  always_comb begin
    rif.acc = src_acc;
    rif.round_en = is_writeback || is_rounded_store;
    rif.convergent = state_r.cfg[`ARS_CFG_ROUND_BIT];
    rif.sat_en = state_r.cfg[`ARS_CFG_SAT_BIT];
  end

  // Shifter operand and amount
  logic        amt_neg;
  logic [5:0]  amt_mag;
  logic [4:0]  amt;
  logic [39:0] sh_operand;
  logic [39:0] sh_value;
  logic [15:0] sh_word;

  always_comb begin
    amt_neg = SH_AMOUNT[5];
    amt_mag = amt_neg ? (6'h00 - SH_AMOUNT) : SH_AMOUNT;
    // Out of range amounts are clamped; the shifter reaches 16 at most
    if (amt_mag > `ARS_SHIFT_MAX) begin
      amt = 5'(`ARS_SHIFT_MAX);
    end else begin
      amt = amt_mag[4:0];
    end
    case (SH_SRC)
      ars_pkg::SH_ACC_A: sh_operand = ACC_A;
      ars_pkg::SH_ACC_B: sh_operand = ACC_B;
      ars_pkg::SH_XBUS: begin
        if (amt_neg) begin
          sh_operand = {24'h000000, SH_XDATA};
        end else begin
          sh_operand = {{8{SH_ARITH & SH_XDATA[15]}}, SH_XDATA, 16'h0000};
        end
      end
      default: sh_operand = 40'h0000000000;
    endcase
    if (amt_neg) begin
      sh_value = sh_operand << amt;
      sh_word = sh_value[15:0];
    end else if (SH_ARITH) begin
      sh_value = $signed(sh_operand) >>> amt;
      sh_word = sh_value[31:16];
    end else begin
      sh_value = sh_operand >> amt;
      sh_word = sh_value[31:16];
    end
  end

  // Next state
  always_comb begin
    state_nxt = state_r;
    state_nxt.xw_stb = 1'b0;
    state_nxt.sh_done = 1'b0;
    state_nxt.rdata = 16'h0000;

    // Software writes; hardware pointer updates below take priority
    if (REG_WR) begin
      case (REG_ADDR)
        `ARS_REG_CFG: begin
          state_nxt.cfg = REG_WDATA[1:0];
        end
        `ARS_REG_PTR: begin
          state_nxt.ptr = REG_WDATA;
        end
        default: begin
          state_nxt.cfg = state_r.cfg;
        end
      endcase
    end

    // Read data stand one cycle, unmapped indices read zero
    if (REG_RD) begin
      case (REG_ADDR)
        `ARS_REG_CFG: state_nxt.rdata = {14'h0000, state_r.cfg};
        `ARS_REG_PTR: state_nxt.rdata = state_r.ptr;
        `ARS_REG_LAST: state_nxt.rdata = state_r.last_data;
        `ARS_REG_STATUS: begin
          state_nxt.rdata = 16'h0000;
          state_nxt.rdata[`ARS_STAT_SAT_BIT] = state_r.last_sat;
          state_nxt.rdata[`ARS_STAT_OVF_BIT] = state_r.last_ovf;
          state_nxt.rdata[`ARS_STAT_DEST_BIT] = state_r.last_dest;
        end
        default: state_nxt.rdata = 16'h0000;
      endcase
    end

    // Accumulator store to the requested address
    if (is_store) begin
      state_nxt.xw_stb = 1'b1;
      state_nxt.xw_addr = OP_ADDR;
      state_nxt.xw_data = rif.data;
    end

    // Multiply-accumulate write-back of the other accumulator
    if (is_writeback) begin
      case (OP_WB_MODE)
        ars_pkg::WB_REG_DIRECT: begin
          state_nxt.ptr = rif.data;
        end
        ars_pkg::WB_POST_INC: begin
          state_nxt.xw_stb = 1'b1;
          state_nxt.xw_addr = state_r.ptr;
          state_nxt.xw_data = rif.data;
          state_nxt.ptr = state_r.ptr + `ARS_PTR_STEP;
        end
        default: begin
          state_nxt.ptr = state_r.ptr;
        end
      endcase
    end

    // Status of the most recent store of either kind
    if (is_store || is_writeback) begin
      state_nxt.last_data = rif.data;
      state_nxt.last_sat = rif.saturated;
      state_nxt.last_ovf = rif.round_ovf;
      state_nxt.last_dest = use_other;
    end

    // Shifter answers in the cycle after the request
    if (SH_STB) begin
      state_nxt.sh_done = 1'b1;
      state_nxt.sh_result = sh_value;
      state_nxt.sh_word = sh_word;
    end
  end

  // State register; enable low freezes everything
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      state_r <= '0;
      state_r.cfg <= `ARS_CFG_RESET;
      state_r.ptr <= `ARS_PTR_RESET;
    end else if (CE) begin
      state_r <= state_nxt;
    end
  end

  // Outputs straight from the state register
  assign REG_RDATA = state_r.rdata;
  assign XW_STB = state_r.xw_stb;
  assign XW_ADDR = state_r.xw_addr;
  assign XW_DATA = state_r.xw_data;
  assign WB_PTR = state_r.ptr;
  assign SH_DONE = state_r.sh_done;
  assign SH_RESULT = state_r.sh_result;
  assign SH_WORD = state_r.sh_word;

endmodule

/* common/ars_consts.svh */
/*
  Offsets, field positions, reset values and limits of the accumulator
  store, round and shift block.
  Assumes inclusion by bare name from the package and the design modules.
*/
`ifndef ARS_CONSTS_SVH
`define ARS_CONSTS_SVH

// Register indices on the plain register port
`define ARS_REG_CFG        4'h0
`define ARS_REG_PTR        4'h1
`define ARS_REG_LAST       4'h2
`define ARS_REG_STATUS     4'h3

// Core configuration field positions
`define ARS_CFG_ROUND_BIT  0
`define ARS_CFG_SAT_BIT    1

// Status field positions
`define ARS_STAT_SAT_BIT   0
`define ARS_STAT_OVF_BIT   1
`define ARS_STAT_DEST_BIT  2

// Reset values
`define ARS_CFG_RESET      2'h0
`define ARS_PTR_RESET      16'h0000

// Post-increment step for a word write
`define ARS_PTR_STEP       16'h0002

// Store saturation limits on the rounded 24-bit high part
`define ARS_SAT_POS_LIMIT  25'h0007FFF
`define ARS_SAT_NEG_LIMIT  25'h0FF8000
`define ARS_SAT_POS_WORD   16'h7FFF
`define ARS_SAT_NEG_WORD   16'h8000
`define ARS_LOW_HALF       16'h8000

// Shifter limits
`define ARS_SHIFT_MAX      6'h10

`endif

/* common/ars_pkg.sv */
/*
  Types of the accumulator store, round and shift block.
  Assumes the constants header is on the include path.
*/
`include "ars_consts.svh"

package ars_pkg;

  // Instruction classes seen by the store path
  typedef enum logic [2:0] {
    OP_NONE,
    OP_STORE_ACC_TRUNCATED,
    OP_STORE_ACC_ROUNDED,
    OP_MULTIPLY_ACCUMULATE_CLASS,
    OP_PLAIN_MULTIPLY,
    OP_NEGATED_MULTIPLY,
    OP_DISTANCE_SQUARED,
    OP_DISTANCE_SQUARED_ACCUMULATE
  } ars_op_type;

  // Write-back addressing modes
  typedef enum logic [1:0] {
    WB_NONE,
    WB_REG_DIRECT,
    WB_POST_INC
  } ars_wb_type;

  // Shifter operand sources
  typedef enum logic [1:0] {
    SH_ACC_A,
    SH_ACC_B,
    SH_XBUS
  } ars_shsrc_type;

  typedef struct packed {
    logic [1:0]  cfg;
    logic [15:0] ptr;
    logic [15:0] last_data;
    logic        last_sat;
    logic        last_ovf;
    logic        last_dest;
    logic        xw_stb;
    logic [15:0] xw_addr;
    logic [15:0] xw_data;
    logic [15:0] rdata;
    logic        sh_done;
    logic [39:0] sh_result;
    logic [15:0] sh_word;
  } ars_state_type;

endpackage

/* common/ars_round_if.sv */
/*
  Carrier between the store path and its round and saturation unit.
  Assumes both ends run combinationally within one clock cycle.
*/
`timescale 1ns/1ps

interface ars_round_if;
  logic [39:0] acc;
  logic        round_en;
  logic        convergent;
  logic        sat_en;
  logic [15:0] data;
  logic        saturated;
  logic        round_ovf;

  modport core (
    output acc,
    output round_en,
    output convergent,
    output sat_en,
    input  data,
    input  saturated,
    input  round_ovf
  );

  modport unit (
    input  acc,
    input  round_en,
    input  convergent,
    input  sat_en,
    output data,
    output saturated,
    output round_ovf
  );
endinterface

/* hdl/ars_round_sat.sv */
/*
  Combinational round logic followed by data space write saturation.
  Assumes the caller supplies the source accumulator and mode bits.
*/
`timescale 1ns/1ps
`include "ars_consts.svh"

module ars_round_sat (
  // Operand and result
  ars_round_if.unit rif
);

  logic        inc;
  logic        low_half;
  logic [24:0] sum;
  logic        sign;
  logic        pos_over;
  logic        neg_over;

  always_comb begin
    low_half = (rif.acc[15:0] == `ARS_LOW_HALF);
    // Exact half goes to the even neighbour only in convergent mode
    if (!rif.round_en) begin
      inc = 1'b0;
    end else if (rif.convergent && low_half) begin
      inc = rif.acc[16];
    end else begin
      inc = rif.acc[15];
    end
    // Whole upper part is carried so the limit tests see the guard bits
    sum = {1'b0, rif.acc[39:16]} + {24'h000000, inc};
    sign = rif.acc[39];
    rif.round_ovf = inc && (rif.acc[31:16] == `ARS_SAT_POS_WORD);
    pos_over = !sign && (sum > `ARS_SAT_POS_LIMIT);
    neg_over = sign && !sum[24] && (sum < `ARS_SAT_NEG_LIMIT);
    if (rif.sat_en && pos_over) begin
      rif.data = `ARS_SAT_POS_WORD;
      rif.saturated = 1'b1;
    end else if (rif.sat_en && neg_over) begin
      rif.data = `ARS_SAT_NEG_WORD;
      rif.saturated = 1'b1;
    end else begin
      rif.data = sum[15:0];
      rif.saturated = 1'b0;
    end
  end

endmodule

/* verif/ars_store_path_chk.sv */
/*
  Port-level assertions for the store path.
  Assumes binding to the top module; one clock, sync reset.
*/
`timescale 1ns/1ps

module ars_store_path_chk (
  // Clock and reset
  input wire logic                  CLK,
  input wire logic                  NRST,
  input wire logic                  CE,
  // Store request
  input wire logic                  OP_STB,
  input wire ars_pkg::ars_op_type   OP_CODE,
  input wire logic                  OP_DEST,
  input wire ars_pkg::ars_wb_type   OP_WB_MODE,
  input wire logic [15:0]           OP_ADDR,
  input wire logic [39:0]           ACC_A,
  // X write bus and pointer
  input wire logic                  XW_STB,
  input wire logic [15:0]           XW_ADDR,
  input wire logic [15:0]           XW_DATA,
  input wire logic [15:0]           WB_PTR,
  // Shifter
  input wire logic                  SH_STB,
  input wire ars_pkg::ars_shsrc_type SH_SRC,
  input wire logic [5:0]            SH_AMOUNT,
  input wire logic [15:0]           SH_XDATA,
  input wire logic                  SH_DONE,
  input wire logic [39:0]           SH_RESULT
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!NRST);

  sequence s_op(ars_pkg::ars_op_type o);
    OP_STB && CE && OP_CODE == o;
  endsequence

  property p_store;
    s_op(ars_pkg::OP_STORE_ACC_TRUNCATED) |=> XW_STB && XW_ADDR == $past(OP_ADDR);
  endproperty
  a_store: assert property (p_store) else $error("store missed the X bus");
  // In-range non-negative values pass whatever the saturation setting
  property p_trunc;
    s_op(ars_pkg::OP_STORE_ACC_TRUNCATED) and (!OP_DEST && ACC_A[39:31] == 9'h000)
      |=> XW_DATA == $past(ACC_A[31:16]);
  endproperty
  a_trunc: assert property (p_trunc) else $error("truncated word wrong");
  property p_nowb;
    OP_STB && CE && OP_CODE inside {ars_pkg::OP_PLAIN_MULTIPLY, ars_pkg::OP_NEGATED_MULTIPLY,
      ars_pkg::OP_DISTANCE_SQUARED, ars_pkg::OP_DISTANCE_SQUARED_ACCUMULATE} |=> !XW_STB;
  endproperty
  a_nowb: assert property (p_nowb) else $error("multiply form wrote back");
  property p_direct;
    s_op(ars_pkg::OP_MULTIPLY_ACCUMULATE_CLASS) and (OP_WB_MODE == ars_pkg::WB_REG_DIRECT)
      |=> !XW_STB;
  endproperty
  a_direct: assert property (p_direct) else $error("direct write-back used the bus");
  property p_postinc;
    s_op(ars_pkg::OP_MULTIPLY_ACCUMULATE_CLASS) and (OP_WB_MODE == ars_pkg::WB_POST_INC)
      |=> XW_STB && XW_ADDR == $past(WB_PTR) && WB_PTR == $past(WB_PTR) + 16'h0002;
  endproperty
  a_postinc: assert property (p_postinc) else $error("post-increment wrong");
  property p_shdone;
    SH_STB && CE |=> SH_DONE;
  endproperty
  a_shdone: assert property (p_shdone) else $error("shift not done in one cycle");
  property p_shzero;
    SH_STB && CE && SH_AMOUNT == 6'h00 && SH_SRC == ars_pkg::SH_ACC_A
      |=> SH_RESULT == $past(ACC_A);
  endproperty
  a_shzero: assert property (p_shzero) else $error("zero shift altered operand");
  property p_shleft;
    SH_STB && CE && SH_AMOUNT == 6'h3C && SH_SRC == ars_pkg::SH_XBUS
      |=> SH_RESULT[19:0] == {$past(SH_XDATA), 4'h0};
  endproperty
  a_shleft: assert property (p_shleft) else $error("bus word misplaced on left shift");

  c_postinc: cover property (s_op(ars_pkg::OP_MULTIPLY_ACCUMULATE_CLASS) ##1 XW_STB);
  c_store: cover property (s_op(ars_pkg::OP_STORE_ACC_ROUNDED) ##1 XW_STB);
  c_shift: cover property (SH_STB && SH_SRC == ars_pkg::SH_XBUS ##1 SH_DONE);
endmodule

bind ars_store_path ars_store_path_chk u_chk (.*);

/* verif/ars_xmem.sv */
/*
  Data memory on the far side of the X write bus.
  Assumes word writes; only 256 words kept, upper address bits ignored.
*/
`timescale 1ns/1ps

module ars_xmem (
  // Clock
  input wire logic        CLK,
  // X write bus
  input wire logic        XW_STB,
  input wire logic [15:0] XW_ADDR,
  input wire logic [15:0] XW_DATA
);
  logic [15:0] mem [0:255];
  int          writes;

  // Any data address is writable, X and Y alike
  always_ff @(posedge CLK) begin
    if (XW_STB) begin
      mem[XW_ADDR[8:1]] <= XW_DATA;
      writes <= writes + 1;
    end
  end
endmodule

/* verif/ars_store_path_bench.sv */
/*
  Self-checking bench for the store path: stores, write-back, shifts.
  Assumes the checker is bound and the memory model sits on the X bus.
*/
`timescale 1ns/1ps
`include "ars_consts.svh"

module ars_store_path_bench;
  logic CLK, NRST, CE, REG_WR, REG_RD, OP_STB, OP_DEST, SH_STB, SH_ARITH, XW_STB, SH_DONE;
  logic [3:0] REG_ADDR;
  logic [15:0] REG_WDATA, REG_RDATA, OP_ADDR, XW_ADDR, XW_DATA, WB_PTR, SH_XDATA, SH_WORD;
  logic [39:0] ACC_A, ACC_B, SH_RESULT;
  logic [5:0] SH_AMOUNT;
  ars_pkg::ars_op_type OP_CODE;
  ars_pkg::ars_wb_type OP_WB_MODE;
  ars_pkg::ars_shsrc_type SH_SRC;
  int fails, checks_done, n0;
  // Even and odd exact halves, below half, round overflow, big negative, big positive
  logic [39:0] av [6] = '{40'h0012348000, 40'h0012358000, 40'h0012347FFF,
                          40'h007FFF8000, 40'hFF00000000, 40'h0100000000};
  int am [5] = '{4, -4, 0, 16, -16};

  ars_store_path DUT (.*);
  ars_xmem u_mem (.CLK(CLK), .XW_STB(XW_STB), .XW_ADDR(XW_ADDR), .XW_DATA(XW_DATA));

  initial begin
    CLK = 1'b0;
    forever #10 CLK = ~CLK;
  end

  function automatic logic [15:0] exp_st(logic [39:0] a, logic r, logic [1:0] c);
    logic        inc;
    logic [23:0] s;
    inc = r & a[15] & (!c[0] | a[15:0] != 16'h8000 | a[16]);
    s = a[39:16] + {23'h0, inc};
    if (c[1] & !a[39] & s > 24'h007FFF) return 16'h7FFF;
    if (c[1] & a[39] & s < 24'hFF8000) return 16'h8000;
    return s[15:0];
  endfunction

  task automatic summarize;
    if (fails == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(string n, logic [39:0] s, logic [39:0] e);
    checks_done++;
    if (s !== e) begin
      fails++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic regw(logic [3:0] a, logic [15:0] d);
    @(posedge CLK);
    REG_ADDR <= a;
    REG_WDATA <= d;
    REG_WR <= 1'b1;
    @(posedge CLK);
    REG_WR <= 1'b0;
  endtask

  task automatic regr(logic [3:0] a, logic [15:0] e);
    @(posedge CLK);
    REG_ADDR <= a;
    REG_RD <= 1'b1;
    @(posedge CLK);
    REG_RD <= 1'b0;
    #1 chk("rdata", 40'(REG_RDATA), 40'(e));
  endtask

  task automatic st(ars_pkg::ars_op_type o, logic d, ars_pkg::ars_wb_type w,
                    logic [39:0] a, logic [39:0] b, logic s, logic [15:0] e);
    @(posedge CLK);
    OP_CODE <= o;
    OP_DEST <= d;
    OP_WB_MODE <= w;
    ACC_A <= a;
    ACC_B <= b;
    OP_STB <= 1'b1;
    @(posedge CLK);
    OP_STB <= 1'b0;
    #1 chk("xw_stb", 40'(XW_STB), 40'(s));
    if (s) chk("xw_data", 40'(XW_DATA), 40'(e));
    if (s && o < ars_pkg::OP_MULTIPLY_ACCUMULATE_CLASS) chk("xw_addr", 40'(XW_ADDR), 40'h0800);
  endtask

  task automatic sh(ars_pkg::ars_shsrc_type src, int n, logic ar);
    logic [39:0] v, r;
    @(posedge CLK);
    // X word sits high for right and zero shifts, low for left
    v = src == ars_pkg::SH_XBUS ? (n < 0 ? {24'h0, SH_XDATA} :
        {{8{ar & SH_XDATA[15]}}, SH_XDATA, 16'h0}) : (src == ars_pkg::SH_ACC_B ? ACC_B : ACC_A);
    r = n > 0 ? (ar ? 40'($signed(v) >>> n) : v >> n) : v << -n;
    SH_SRC <= src;
    SH_AMOUNT <= 6'(n);
    SH_ARITH <= ar;
    SH_STB <= 1'b1;
    @(posedge CLK);
    SH_STB <= 1'b0;
    #1 chk("sh_done", 40'(SH_DONE), 40'h1);
    chk("sh_result", SH_RESULT, r);
    chk("sh_word", 40'(SH_WORD), 40'(n < 0 ? r[15:0] : r[31:16]));
  endtask

  initial begin
    {CE, REG_WR, REG_RD, OP_STB, OP_DEST, SH_STB, SH_ARITH, NRST} = '0;
    {REG_ADDR, REG_WDATA, ACC_A, ACC_B, SH_AMOUNT} = '0;
    OP_CODE = ars_pkg::OP_NONE;
    OP_WB_MODE = ars_pkg::WB_NONE;
    OP_ADDR = 16'h0800;
    SH_SRC = ars_pkg::SH_ACC_A;
    SH_XDATA = 16'hA5C3;
    repeat (4) @(posedge CLK);
    NRST <= 1'b1;
    CE <= 1'b1;
    regr(`ARS_REG_PTR, 16'h0000);
    regr(`ARS_REG_CFG, 16'h0000);
    regr(4'hF, 16'h0000);
    for (int c = 0; c < 4; c++) begin
      regw(`ARS_REG_CFG, 16'(c));
      regr(`ARS_REG_CFG, 16'(c));
      for (int k = 0; k < 6; k++) begin
        st(ars_pkg::OP_STORE_ACC_TRUNCATED, 1'b0, ars_pkg::WB_NONE, av[k], 40'h0, 1'b1,
           exp_st(av[k], 1'b0, 2'(c)));
        st(ars_pkg::OP_STORE_ACC_ROUNDED, 1'b1, ars_pkg::WB_NONE, 40'h0055550000, av[k], 1'b1,
           exp_st(av[k], 1'b1, 2'(c)));
        regw(`ARS_REG_PTR, 16'h0100);
        st(ars_pkg::OP_MULTIPLY_ACCUMULATE_CLASS, 1'b0, ars_pkg::WB_POST_INC, 40'h0055550000,
           av[k], 1'b1, exp_st(av[k], 1'b1, 2'(c)));
        chk("wb_ptr", 40'(WB_PTR), 40'h0102);
        // Memory takes the word on the edge after the bus strobe
        @(posedge CLK);
        #1 chk("mem", 40'(u_mem.mem[8'h80]), 40'(exp_st(av[k], 1'b1, 2'(c))));
        st(ars_pkg::OP_MULTIPLY_ACCUMULATE_CLASS, 1'b1, ars_pkg::WB_REG_DIRECT, av[k], 40'h0,
           1'b0, 16'h0000);
        chk("wb_ptr", 40'(WB_PTR), 40'(exp_st(av[k], 1'b1, 2'(c))));
      end
    end
    n0 = u_mem.writes;
    for (int o = 4; o < 8; o++) begin
      st(ars_pkg::ars_op_type'(o), 1'b0, ars_pkg::WB_POST_INC, 40'h0, av[0], 1'b0, 16'h0);
    end
    chk("writes", 40'(u_mem.writes), 40'(n0));
    // Last write-back saturated positive from accumulator A, no round carry
    regr(`ARS_REG_LAST, 16'h7FFF);
    regr(`ARS_REG_STATUS, 16'h0001);
    ACC_A <= 40'h8F12345678;
    ACC_B <= 40'h0123456789;
    for (int i = 0; i < 5; i++) begin
      for (int s = 0; s < 6; s++) begin
        sh(ars_pkg::ars_shsrc_type'(s / 2), am[i], s[0]);
      end
    end
    summarize;
  end

  // Whole run is under a thousand cycles
  initial begin
    repeat (5000) @(posedge CLK);
    fails++;
    summarize;
  end
endmodule
